// File: rtl/bus_cond_detect.v
// Start, Stop and clock edge detector for the two-wire bus
`timescale 1ns/100ps
module bus_cond_detect (
  // Clock and reset
  input wire sys_clk,
  input wire rst_b,
  // Bus levels
  input wire scl_in,
  input wire sda_in,
  // Detected events
  output wire scl_rise,
  output wire scl_fall,
  output wire start_seen,
  output wire stop_seen
);

  reg scl_q;
  reg sda_q;

  always @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      scl_q <= 1'b1;
      sda_q <= 1'b1;
    end else begin
      scl_q <= scl_in;
      sda_q <= sda_in;
    end
  end

  assign scl_rise = scl_in & ~scl_q;
  assign scl_fall = ~scl_in & scl_q;
  // Data falls or rises while clock stays high
  assign start_seen = scl_in & scl_q & sda_q & ~sda_in;
  assign stop_seen = scl_in & scl_q & ~sda_q & sda_in;

endmodule // bus_cond_detect

// File: rtl/sync_serial_two_wire_port.v
// Two-wire serial bus port: master and slave engines with register file
//
// How it works
// R1 - Port works as bus master or slave and answers the general call address; the code answers it only in the 7-bit slave modes.
// R2 - Detected Start and Stop conditions raise interrupts for bus-free decisions.
// R3 - Standard-mode timing; slave accepts 7-bit and 10-bit addresses.
// R4 - Software sets clock and data pin directions in the port direction register; no such register here, scl_oe and sda_oe come from the engines.
// R5 - Control registers read/write; status low six bits read-only, top two read/write.
// R6 - Shift register is not reachable by software.
// R7 - Address register: own slave address, or low seven bits as baud reload.
// R8 - Receive double-buffered: finished byte moves to buffer and sets interrupt flag.
// R9 - Buffer write loads buffer and shift register together.
// R10 - Status bit 7 selects slew rate control off (set) or on (clear).
// R11 - Stop bit marks last condition was Stop; cleared on reset and disable.
// R12 - Start bit marks last condition was Start; cleared on reset and disable.
// R13 - Slave status bit 5 tells data (1) or address (0) for last byte.
// R14 - Slave status bit 2 holds read/write from last match until Start, Stop, nack.
// R15 - Status bit 6 enables bus-management compliant input thresholds.
// R16 - Mode field selects master, 7/10-bit slave, firmware master, Start/Stop modes.
// R17 - Overflow flag set when byte completes while buffer unread; software clears.
`timescale 1ns/100ps
`include "two_wire_port_defs.vh"
module sync_serial_two_wire_port (
  // Clock and reset
  input wire sys_clk,
  input wire rst_b,
  // Register port
  input wire [2:0] reg_addr,
  input wire [7:0] reg_wdata,
  input wire reg_wr,
  input wire reg_rd,
  output reg [7:0] reg_rdata,
  // Two-wire bus pins, open drain
  input wire scl_in,
  output wire scl_out,
  output wire scl_oe,
  input wire sda_in,
  output wire sda_out,
  output wire sda_oe,
  // Pad configuration
  output wire slew_ctrl_off,
  output wire smbus_levels,
  // Interrupt
  output wire irq
);

  localparam M_IDLE = 3'd0;
  localparam M_START = 3'd1;
  localparam M_STOP = 3'd2;
  localparam M_TX = 3'd3;
  localparam M_RX = 3'd4;
  localparam M_ACK = 3'd5;

  // R16 - mode decoding
  function is_slave_mode;
    input [3:0] m;
    begin
      is_slave_mode = (m == `MODE_SLV7) || (m == `MODE_SLV10) || (m == `MODE_SLV7_SP) || (m == `MODE_SLV10_SP);
    end
  endfunction

  function is_ten_bit;
    input [3:0] m;
    begin
      is_ten_bit = (m == `MODE_SLV10) || (m == `MODE_SLV10_SP);
    end
  endfunction

  function cond_irq_mode;
    input [3:0] m;
    begin
      cond_irq_mode = (m == `MODE_SLV7_SP) || (m == `MODE_SLV10_SP) || (m == `MODE_MASTER) || (m == `MODE_FW_MASTER);
    end
  endfunction

  reg [7:0] ctl1_reg;
  reg [7:0] ctl2_reg;
  reg [1:0] smp_cke_reg;
  reg data_addr_reg;
  reg stop_reg;
  reg start_reg;
  reg rw_reg;
  reg ua_reg;
  reg bf_reg;
  reg [7:0] buf_reg;
  reg [7:0] shift_reg;
  reg [7:0] addr_reg;
  reg [4:0] irq_stat_reg;
  reg [4:0] irq_en_reg;
  reg ev_done_reg;
  reg ev_ov_reg;
  reg ev_col_reg;
  reg ev_start_reg;
  reg ev_stop_reg;
  // Slave engine
  reg [3:0] s_cnt;
  reg s_addr_phase;
  reg s_active;
  reg s_tx;
  reg s_second;
  reg s_ten_ok;
  reg [1:0] s_hi_reg;
  reg s_sda_low;
  reg s_scl_low;
  // Master engine
  reg [2:0] m_state;
  reg [1:0] m_ph;
  reg [3:0] m_bit;
  reg [6:0] brg_reg;
  reg m_sda_low;
  reg m_scl_low;

  wire scl_rise;
  wire scl_fall;
  wire start_seen;
  wire stop_seen;

  bus_cond_detect u_cond (
    .sys_clk(sys_clk),
    .rst_b(rst_b),
    .scl_in(scl_in),
    .sda_in(sda_in),
    .scl_rise(scl_rise),
    .scl_fall(scl_fall),
    .start_seen(start_seen),
    .stop_seen(stop_seen)
  );

  wire en = ctl1_reg[`C1_EN];
  wire [3:0] mode = ctl1_reg[3:0];
  wire master_on = en && (mode == `MODE_MASTER);
  wire slave_on = en && is_slave_mode(mode);
  wire ten = is_ten_bit(mode);
  wire wr_buf = reg_wr && (reg_addr == `A_BUF);
  wire rd_buf = reg_rd && (reg_addr == `A_BUF);
  wire tick = (brg_reg == 7'h00);
  wire m_stall = (m_ph == 2'd2) && !scl_in;
  wire [4:0] irq_clr = (reg_wr && (reg_addr == `A_IRQ_CLR)) ? reg_wdata[4:0] : 5'h00;

  // R1 - own address or general call
  wire hit7 = (shift_reg[7:1] == addr_reg[7:1]);
  wire gc_hit = ctl2_reg[`C2_GCEN] && (shift_reg == `GEN_CALL_ADDR);
  // R3 - ten-bit header, low byte and read header
  wire hdr = (shift_reg[7:3] == `TEN_BIT_HDR);
  wire hi_hit = hdr && !shift_reg[0] && hit7 && !s_second;
  wire rd_hi_hit = hdr && shift_reg[0] && s_ten_ok && (shift_reg[2:1] == s_hi_reg);
  wire lo_hit = s_second && (shift_reg == addr_reg);
  wire addr_hit = ten ? (hi_hit || rd_hi_hit || lo_hit) : (hit7 || gc_hit);

  wire m_drive = (m_state == M_TX && m_bit < 4'd8) ? ~shift_reg[7] :
                 ((m_state == M_ACK) ? ~ctl2_reg[`C2_ACKDT] : 1'b0);
  wire [3:0] m_last = (m_state == M_TX) ? 4'd8 : ((m_state == M_RX) ? 4'd7 : 4'd0);

  // R8 - receive capture, R17 - overflow
  task capture_byte;
    input [7:0] b;
    begin
      if (bf_reg) begin
        ctl1_reg[`C1_OV] <= 1'b1;
        ev_ov_reg <= 1'b1;
      end else begin
        buf_reg <= b;
        bf_reg <= 1'b1;
      end
      ev_done_reg <= 1'b1;
    end
  endtask

  always @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      ctl1_reg <= `RST_BYTE;
      ctl2_reg <= `RST_BYTE;
      smp_cke_reg <= 2'b00;
      data_addr_reg <= 1'b0;
      stop_reg <= 1'b0;
      start_reg <= 1'b0;
      rw_reg <= 1'b0;
      ua_reg <= 1'b0;
      bf_reg <= 1'b0;
      buf_reg <= `RST_BYTE;
      shift_reg <= `RST_BYTE;
      addr_reg <= `RST_BYTE;
      irq_stat_reg <= `RST_IRQ;
      irq_en_reg <= `RST_IRQ;
      ev_done_reg <= 1'b0;
      ev_ov_reg <= 1'b0;
      ev_col_reg <= 1'b0;
      ev_start_reg <= 1'b0;
      ev_stop_reg <= 1'b0;
      s_cnt <= 4'd0;
      s_addr_phase <= 1'b0;
      s_active <= 1'b0;
      s_tx <= 1'b0;
      s_second <= 1'b0;
      s_ten_ok <= 1'b0;
      s_hi_reg <= 2'b00;
      s_sda_low <= 1'b0;
      s_scl_low <= 1'b0;
      m_state <= M_IDLE;
      m_ph <= 2'd0;
      m_bit <= 4'd0;
      brg_reg <= 7'h00;
      m_sda_low <= 1'b0;
      m_scl_low <= 1'b0;
    end else begin
      ev_done_reg <= 1'b0;
      ev_ov_reg <= 1'b0;
      ev_col_reg <= 1'b0;
      ev_start_reg <= start_seen && en && cond_irq_mode(mode);
      ev_stop_reg <= stop_seen && en && cond_irq_mode(mode);
      // R5 - register writes; status low bits stay hardware-owned
      if (reg_wr) begin
        case (reg_addr)
          `A_CTL1: ctl1_reg <= reg_wdata;
          `A_CTL2: ctl2_reg <= reg_wdata;
          `A_STAT: smp_cke_reg <= reg_wdata[7:6];
          `A_ADDR: begin
            addr_reg <= reg_wdata;
            ua_reg <= 1'b0;
          end
          `A_IRQ_EN: irq_en_reg <= reg_wdata[4:0];
          default: ;
        endcase
      end
      // R9 - transmit write loads buffer and shifter
      if (wr_buf) begin
        if ((master_on && m_state != M_IDLE) || (s_tx && s_cnt != 4'd0 && s_cnt < 4'd8)) begin
          ctl1_reg[`C1_WCOL] <= 1'b1;
          ev_col_reg <= 1'b1;
        end else begin
          buf_reg <= reg_wdata;
          shift_reg <= reg_wdata;
          bf_reg <= 1'b1;
          if (master_on) begin
            m_state <= M_TX;
            m_ph <= 2'd0;
            m_bit <= 4'd0;
          end
        end
      end else if (rd_buf && !s_tx && m_state != M_TX) begin
        bf_reg <= 1'b0;
      end
      // R12 - Start seen
      if (start_seen) begin
        start_reg <= 1'b1;
        stop_reg <= 1'b0;
        s_cnt <= 4'd0;
        s_addr_phase <= slave_on;
        s_active <= 1'b0;
        s_tx <= 1'b0;
        s_second <= 1'b0;
        s_sda_low <= 1'b0;
        // R14 - direction invalid after Start
        rw_reg <= 1'b0;
      end else if (stop_seen) begin
        // R11 - Stop seen
        stop_reg <= 1'b1;
        start_reg <= 1'b0;
        s_cnt <= 4'd0;
        s_addr_phase <= 1'b0;
        s_active <= 1'b0;
        s_tx <= 1'b0;
        s_second <= 1'b0;
        s_ten_ok <= 1'b0;
        s_sda_low <= 1'b0;
        rw_reg <= 1'b0;
      end else if (slave_on && (s_addr_phase || s_active)) begin
        if (scl_rise && s_cnt < 4'd8) begin
          shift_reg <= {shift_reg[6:0], sda_in};
          s_cnt <= s_cnt + 4'd1;
          if (s_tx && s_cnt == 4'd7) begin
            bf_reg <= 1'b0;
          end
        end else if (scl_rise && s_tx && s_cnt == 4'd8) begin
          s_cnt <= 4'd0;
          ev_done_reg <= 1'b1;
          data_addr_reg <= 1'b1;
          if (sda_in) begin
            // R14 - missing acknowledge ends the read
            s_tx <= 1'b0;
            s_active <= 1'b0;
            rw_reg <= 1'b0;
          end else begin
            ctl1_reg[`C1_CKP] <= 1'b0;
          end
        end
        if (scl_fall && s_cnt == 4'd8 && !s_tx) begin
          s_cnt <= 4'd9;
          if (s_addr_phase) begin
            if (addr_hit) begin
              capture_byte(shift_reg);
              s_sda_low <= !bf_reg;
              // R13 - address byte
              data_addr_reg <= 1'b0;
              if (hi_hit) begin
                ua_reg <= 1'b1;
                s_hi_reg <= shift_reg[2:1];
                s_second <= 1'b1;
                s_ten_ok <= 1'b0;
              end else if (lo_hit) begin
                ua_reg <= 1'b1;
                s_second <= 1'b0;
                s_ten_ok <= 1'b1;
                s_addr_phase <= 1'b0;
                s_active <= 1'b1;
                rw_reg <= 1'b0;
              end else begin
                s_addr_phase <= 1'b0;
                s_active <= 1'b1;
                // R14 - direction from the match
                rw_reg <= shift_reg[0];
                if (shift_reg[0]) begin
                  s_tx <= 1'b1;
                  ctl1_reg[`C1_CKP] <= 1'b0;
                end
              end
            end else begin
              s_addr_phase <= 1'b0;
              s_second <= 1'b0;
            end
          end else begin
            capture_byte(shift_reg);
            s_sda_low <= !bf_reg;
            // R13 - data byte
            data_addr_reg <= 1'b1;
          end
        end else if (scl_fall && s_cnt == 4'd9) begin
          s_sda_low <= 1'b0;
          s_cnt <= 4'd0;
        end else if (s_tx && s_cnt < 4'd8 && !scl_in) begin
          s_sda_low <= ~shift_reg[7];
        end else if (s_tx && s_cnt == 4'd8) begin
          s_sda_low <= 1'b0;
        end
      end
      // Clock stretch while software has not released the clock
      s_scl_low <= s_tx && !ctl1_reg[`C1_CKP] && (s_scl_low || scl_fall);
      // R1 - master engine
      if (!master_on) begin
        m_state <= M_IDLE;
        m_sda_low <= 1'b0;
        m_scl_low <= 1'b0;
      end else if (m_state == M_IDLE) begin
        // R7 - baud reload from low seven address bits
        brg_reg <= addr_reg[6:0];
        m_ph <= 2'd0;
        m_bit <= 4'd0;
        if (ctl2_reg[`C2_SEN] || ctl2_reg[`C2_RSEN]) begin
          m_state <= M_START;
        end else if (ctl2_reg[`C2_PEN]) begin
          m_state <= M_STOP;
        end else if (ctl2_reg[`C2_RCEN]) begin
          m_state <= M_RX;
        end else if (ctl2_reg[`C2_ACKEN]) begin
          m_state <= M_ACK;
        end
      end else if (!tick) begin
        brg_reg <= brg_reg - 7'd1;
      end else begin
        brg_reg <= addr_reg[6:0];
        if (!m_stall) begin
          m_ph <= m_ph + 2'd1;
        end
        case (m_state)
          M_START: begin
            case (m_ph)
              2'd0: m_sda_low <= 1'b0;
              2'd1: m_scl_low <= 1'b0;
              2'd2: m_sda_low <= 1'b1;
              default: begin
                m_scl_low <= 1'b1;
                m_state <= M_IDLE;
                ctl2_reg[`C2_SEN] <= 1'b0;
                ctl2_reg[`C2_RSEN] <= 1'b0;
                ev_done_reg <= 1'b1;
              end
            endcase
          end
          M_STOP: begin
            case (m_ph)
              2'd0: m_sda_low <= 1'b1;
              2'd1: m_scl_low <= 1'b0;
              2'd2: m_sda_low <= 1'b0;
              default: begin
                m_state <= M_IDLE;
                ctl2_reg[`C2_PEN] <= 1'b0;
                ev_done_reg <= 1'b1;
              end
            endcase
          end
          default: begin
            case (m_ph)
              2'd0: m_sda_low <= m_drive;
              2'd1: m_scl_low <= 1'b0;
              2'd2: begin
                if (!m_stall && m_state == M_TX && m_bit == 4'd8) begin
                  ctl2_reg[`C2_ACKSTAT] <= sda_in;
                end
                if (!m_stall && m_state == M_RX) begin
                  shift_reg <= {shift_reg[6:0], sda_in};
                end
              end
              default: begin
                m_scl_low <= 1'b1;
                m_bit <= m_bit + 4'd1;
                if (m_state == M_TX) begin
                  shift_reg <= {shift_reg[6:0], 1'b0};
                end
                if (m_bit == m_last) begin
                  m_state <= M_IDLE;
                  m_sda_low <= 1'b0;
                  if (m_state == M_TX) begin
                    bf_reg <= 1'b0;
                    ev_done_reg <= 1'b1;
                  end else if (m_state == M_RX) begin
                    capture_byte(shift_reg);
                    ctl2_reg[`C2_RCEN] <= 1'b0;
                  end else begin
                    ctl2_reg[`C2_ACKEN] <= 1'b0;
                    ev_done_reg <= 1'b1;
                  end
                end
              end
            endcase
          end
        endcase
      end
      // R2 - sticky events, set wins over clear
      irq_stat_reg <= (irq_stat_reg & ~irq_clr) | {ev_col_reg, ev_ov_reg, ev_stop_reg, ev_start_reg, ev_done_reg};
      // R11 - disable clears bus condition bits and engines
      if (!en) begin
        start_reg <= 1'b0;
        stop_reg <= 1'b0;
        s_cnt <= 4'd0;
        s_addr_phase <= 1'b0;
        s_active <= 1'b0;
        s_tx <= 1'b0;
        s_sda_low <= 1'b0;
        s_scl_low <= 1'b0;
      end
    end
  end

  // R6 - shifter never appears on the read mux
  always @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      reg_rdata <= `RST_BYTE;
    end else if (reg_rd) begin
      case (reg_addr)
        `A_CTL1: reg_rdata <= ctl1_reg;
        `A_CTL2: reg_rdata <= ctl2_reg;
        `A_STAT: reg_rdata <= {smp_cke_reg, data_addr_reg, stop_reg, start_reg, rw_reg, ua_reg, bf_reg};
        `A_BUF: reg_rdata <= buf_reg;
        `A_ADDR: reg_rdata <= addr_reg;
        `A_IRQ_STAT: reg_rdata <= {3'b000, irq_stat_reg};
        `A_IRQ_EN: reg_rdata <= {3'b000, irq_en_reg};
        default: reg_rdata <= `RST_BYTE;
      endcase
    end else begin
      reg_rdata <= `RST_BYTE;
    end
  end

  // R4 - pins only pulled low while enabled
  assign scl_out = 1'b0;
  assign sda_out = 1'b0;
  assign scl_oe = en && (m_scl_low || s_scl_low);
  assign sda_oe = en && (m_sda_low || s_sda_low);
  // R10 - slew control select
  assign slew_ctrl_off = smp_cke_reg[1];
  // R15 - input threshold select
  assign smbus_levels = smp_cke_reg[0];
  assign irq = |(irq_stat_reg & irq_en_reg);

endmodule // sync_serial_two_wire_port

// File: rtl/two_wire_port_defs.vh
// Register map, field positions, reset values and mode codes of the two-wire port
`ifndef TWO_WIRE_PORT_DEFS_VH
`define TWO_WIRE_PORT_DEFS_VH

// Register indices on the register port
`define A_CTL1 3'h0
`define A_CTL2 3'h1
`define A_STAT 3'h2
`define A_BUF 3'h3
`define A_ADDR 3'h4
`define A_IRQ_STAT 3'h5
`define A_IRQ_CLR 3'h6
`define A_IRQ_EN 3'h7

// port_control_one fields
`define C1_WCOL 7
`define C1_OV 6
`define C1_EN 5
`define C1_CKP 4

// port_control_two fields
`define C2_GCEN 7
`define C2_ACKSTAT 6
`define C2_ACKDT 5
`define C2_ACKEN 4
`define C2_RCEN 3
`define C2_PEN 2
`define C2_RSEN 1
`define C2_SEN 0

// mode_select_field codes
`define MODE_MASTER 4'h8
`define MODE_SLV7 4'h6
`define MODE_SLV10 4'h7
`define MODE_FW_MASTER 4'hb
`define MODE_SLV7_SP 4'he
`define MODE_SLV10_SP 4'hf

// Interrupt status bits
`define IRQ_DONE 0
`define IRQ_START 1
`define IRQ_STOP 2
`define IRQ_OV 3
`define IRQ_COL 4
`define IRQ_W 5

// Reset values and fixed addresses
`define RST_BYTE 8'h00
`define RST_IRQ 5'h00
`define GEN_CALL_ADDR 8'h00
`define TEN_BIT_HDR 5'h1e

`endif

// File: verif/sync_serial_two_wire_port_tb.sv
// Self-checking bench for the two-wire port in slave and master use
`timescale 1ns/100ps
`include "two_wire_port_defs.vh"
module sync_serial_two_wire_port_tb;
  reg sys_clk = 1'b0;
  reg rst_b = 1'b0;
  reg [2:0] reg_addr = 3'h0;
  reg [7:0] reg_wdata = 8'h00;
  reg reg_wr = 1'b0;
  reg reg_rd = 1'b0;
  wire [7:0] reg_rdata;
  wire scl_out, scl_oe, sda_out, sda_oe, slew_ctrl_off, smbus_levels, irq, scl_lo, sda_lo;
  wire scl = !(scl_oe || scl_lo);
  wire sda = !(sda_oe || sda_lo);
  integer err_total = 0;
  integer samples_checked = 0;
  integer i;
  reg [7:0] d;
  reg [7:0] own;
  logic nack;
  reg [7:0] exp_q[$];
  reg [3:0] modes [0:5];

  always #50 sys_clk = ~sys_clk;

  sync_serial_two_wire_port dut (
    .sys_clk(sys_clk), .rst_b(rst_b), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .scl_in(scl),
    .scl_out(scl_out), .scl_oe(scl_oe), .sda_in(sda), .sda_out(sda_out), .sda_oe(sda_oe),
    .slew_ctrl_off(slew_ctrl_off), .smbus_levels(smbus_levels), .irq(irq)
  );
  two_wire_bus_master peer (.clk(sys_clk), .scl(scl), .sda(sda), .scl_lo(scl_lo), .sda_lo(sda_lo));

  task test_done;
    begin
      $display("compared %0d, mismatched %0d", samples_checked, err_total);
      if (err_total == 0 && samples_checked > 0) begin
        $display("NO MISMATCHES");
      end else begin
        $display("MISMATCHES SEEN");
      end
      $finish;
    end
  endtask
  task chk(input [7:0] seen, input [7:0] exp);
    begin
      samples_checked = samples_checked + 1;
      if (seen !== exp) begin
        err_total = err_total + 1;
        $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
      end
    end
  endtask
  task wr(input [2:0] a, input [7:0] v);
    begin
      reg_addr <= a;
      reg_wdata <= v;
      reg_wr <= 1'b1;
      @(posedge sys_clk);
      reg_wr <= 1'b0;
      @(posedge sys_clk);
    end
  endtask
  task rd(input [2:0] a, output [7:0] v);
    begin
      reg_addr <= a;
      reg_rd <= 1'b1;
      @(posedge sys_clk);
      reg_rd <= 1'b0;
      @(posedge sys_clk);
      v = reg_rdata;
    end
  endtask
  task rchk(input [2:0] a, input [7:0] exp);
    reg [7:0] v;
    begin
      rd(a, v);
      chk(v, exp);
    end
  endtask

  initial begin
    #(100 * 40000);
    err_total = err_total + 1;
    test_done;
  end

  initial begin
    modes[0] = `MODE_SLV7;
    modes[1] = `MODE_SLV10;
    modes[2] = `MODE_MASTER;
    modes[3] = `MODE_FW_MASTER;
    modes[4] = `MODE_SLV7_SP;
    modes[5] = `MODE_SLV10_SP;
    d = $urandom(32'h7986);
    repeat (5) @(posedge sys_clk);
    rst_b <= 1'b1;
    @(posedge sys_clk);
    for (i = 0; i < 8; i = i + 1) rchk(i[2:0], 8'h00);
    for (i = 0; i < 6; i = i + 1) begin
      wr(`A_CTL1, {4'h0, modes[i]});
      rchk(`A_CTL1, {4'h0, modes[i]});
    end
    d = $urandom;
    wr(`A_ADDR, d);
    rchk(`A_ADDR, d);
    wr(`A_CTL2, 8'ha0);
    rchk(`A_CTL2, 8'ha0);
    wr(`A_STAT, 8'hff);
    rchk(`A_STAT, 8'hc0);
    chk({6'h00, slew_ctrl_off, smbus_levels}, 8'h03);
    wr(`A_STAT, 8'h00);
    d = $urandom;
    wr(`A_BUF, d);
    rchk(`A_BUF, d);
    // Slave reception at a random own address
    d = $urandom % 96;
    own = (d + 8'h10) << 1;
    wr(`A_ADDR, own);
    wr(`A_IRQ_EN, 8'h1f);
    wr(`A_CTL1, 8'h2e);
    peer.start_cond;
    rchk(`A_STAT, 8'h08);
    peer.send_byte(own, nack);
    chk({7'h00, nack}, 8'h00);
    rchk(`A_STAT, 8'h09);
    rchk(`A_BUF, own);
    for (i = 0; i < 3; i = i + 1) begin
      d = $urandom;
      exp_q.push_back(d);
      peer.send_byte(d, nack);
      chk({7'h00, nack}, {7'h00, i == 2});
      if (i == 0) begin
        rchk(`A_STAT, 8'h29);
        rchk(`A_BUF, exp_q.pop_front());
      end
    end
    rchk(`A_CTL1, 8'h6e);
    rchk(`A_BUF, exp_q.pop_front());
    exp_q.delete();
    wr(`A_CTL1, 8'h2e);
    rchk(`A_CTL1, 8'h2e);
    peer.start_cond;
    peer.send_byte(8'h00, nack);
    chk({7'h00, nack}, 8'h00);
    rchk(`A_BUF, 8'h00);
    peer.stop_cond;
    rchk(`A_STAT, 8'h10);
    rchk(`A_IRQ_STAT, 8'h0f);
    chk({7'h00, irq}, 8'h01);
    wr(`A_IRQ_EN, 8'h00);
    chk({7'h00, irq}, 8'h00);
    wr(`A_IRQ_EN, 8'h1f);
    chk({7'h00, irq}, 8'h01);
    wr(`A_IRQ_CLR, 8'h1f);
    chk({7'h00, irq}, 8'h00);
    rchk(`A_IRQ_STAT, 8'h00);
    // Ten-bit slave: header byte, then low address byte
    wr(`A_CTL1, 8'h27);
    wr(`A_ADDR, 8'hf0);
    peer.start_cond;
    peer.send_byte(8'hf0, nack);
    chk({7'h00, nack}, 8'h00);
    rchk(`A_STAT, 8'h0b);
    rchk(`A_BUF, 8'hf0);
    d = $urandom;
    wr(`A_ADDR, d);
    rchk(`A_STAT, 8'h08);
    peer.send_byte(d, nack);
    chk({7'h00, nack}, 8'h00);
    rchk(`A_STAT, 8'h0b);
    rchk(`A_BUF, d);
    peer.stop_cond;
    wr(`A_ADDR, 8'hf0);
    wr(`A_CTL1, 8'h00);
    rchk(`A_STAT, 8'h00);
    // Master start with a baud reload of one
    wr(`A_ADDR, 8'h01);
    wr(`A_CTL1, 8'h28);
    wr(`A_CTL2, 8'h81);
    d = 8'h01;
    for (i = 0; i < 100 && d[0]; i = i + 1) rd(`A_CTL2, d);
    chk({7'h00, d[0]}, 8'h00);
    rchk(`A_STAT, 8'h08);
    chk({7'h00, scl_oe}, 8'h01);
    wr(`A_CTL1, 8'h00);
    rchk(`A_STAT, 8'h00);
    test_done;
  end
endmodule // sync_serial_two_wire_port_tb

// File: verif/two_wire_bus_master.sv
// Behavioural bus master on the far side of the port
`timescale 1ns/100ps
module two_wire_bus_master #(parameter integer HALF = 30) (
  // Clock
  input wire clk,
  // Resolved bus levels
  input wire scl,
  input wire sda,
  // Pull-low drivers, released lines float high
  output logic scl_lo,
  output logic sda_lo
);
  initial begin
    scl_lo = 1'b0;
    sda_lo = 1'b0;
  end
  task pause;
    begin
      repeat (HALF) @(posedge clk);
    end
  endtask
  task clk_high;
    begin
      scl_lo <= 1'b0;
      @(posedge clk);
      while (!scl) @(posedge clk);
      pause;
    end
  endtask
  task start_cond;
    begin
      sda_lo <= 1'b0;
      pause;
      clk_high;
      sda_lo <= 1'b1;
      pause;
      scl_lo <= 1'b1;
      pause;
    end
  endtask
  task stop_cond;
    begin
      sda_lo <= 1'b1;
      pause;
      clk_high;
      sda_lo <= 1'b0;
      pause;
    end
  endtask
  // data changes only while clock low
  task send_byte(input [7:0] b, output logic nack);
    integer k;
    begin
      for (k = 7; k >= 0; k = k - 1) begin
        sda_lo <= ~b[k];
        pause;
        clk_high;
        scl_lo <= 1'b1;
        pause;
      end
      sda_lo <= 1'b0;
      pause;
      clk_high;
      nack = sda;
      scl_lo <= 1'b1;
      pause;
    end
  endtask
endmodule // two_wire_bus_master

// File: verif/two_wire_port_checker.sv
// Port-level assertions for the two-wire port, bound to its top module
`timescale 1ns/100ps
module two_wire_port_checker (
  // Clock and reset
  input wire sys_clk,
  input wire rst_b,
  // Register port
  input wire [2:0] reg_addr,
  input wire [7:0] reg_wdata,
  input wire reg_wr,
  input wire reg_rd,
  input wire [7:0] reg_rdata,
  // Bus pins
  input wire scl_in,
  input wire scl_out,
  input wire scl_oe,
  input wire sda_in,
  input wire sda_out,
  input wire sda_oe,
  // Pad configuration and interrupt
  input wire slew_ctrl_off,
  input wire smbus_levels,
  input wire irq
);
  default clocking cb @(posedge sys_clk);
  endclocking
  default disable iff (!rst_b);

  sequence ctl_write;
    reg_wr && reg_addr == 3'h0;
  endsequence
  sequence ctl_readback;
    ctl_write ##2 (reg_rd && reg_addr == 3'h0);
  endsequence
  sequence stat_read;
    reg_rd && reg_addr == 3'h2;
  endsequence

  a_ctl_readback: assert property (ctl_readback |=> reg_rdata == $past(reg_wdata, 3))
    else $error("control read back differs");
  a_rdata_idle: assert property (!$past(reg_rd) |-> reg_rdata == 8'h00)
    else $error("read data outside answer cycle");
  a_stat_bits: assert property (stat_read |=> reg_rdata[7:6] == {slew_ctrl_off, smbus_levels})
    else $error("status top bits differ from pads");
  a_slew_follow: assert property (reg_wr && reg_addr == 3'h2 |=> slew_ctrl_off == ($past(reg_wdata) >= 8'h80))
    else $error("slew control not taken");
  a_smbus_follow: assert property (reg_wr && reg_addr == 3'h2 |=> smbus_levels == (($past(reg_wdata) & 8'h40) != 8'h00))
    else $error("input threshold select not taken");
  a_write_only_read: assert property (reg_rd && reg_addr == 3'h6 |=> reg_rdata == 8'h00)
    else $error("write-only place read non-zero");
  a_open_drain_low: assert property (scl_out == 1'b0 && sda_out == 1'b0)
    else $error("pin driven high");
  a_disable_release: assert property (ctl_write and reg_wdata[5] == 1'b0 |=> !scl_oe && !sda_oe)
    else $error("pins held after disable");
  a_irq_masked: assert property (reg_wr && reg_addr == 3'h7 && reg_wdata == 8'h00 |=> !irq)
    else $error("interrupt while all masked");
  a_irq_cleared: assert property (reg_wr && reg_addr == 3'h6 && reg_wdata == 8'h1f |=> !irq)
    else $error("interrupt after clear of all");
endmodule // two_wire_port_checker

bind sync_serial_two_wire_port two_wire_port_checker chk (
  .sys_clk(sys_clk), .rst_b(rst_b), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
  .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .scl_in(scl_in),
  .scl_out(scl_out), .scl_oe(scl_oe), .sda_in(sda_in), .sda_out(sda_out),
  .sda_oe(sda_oe), .slew_ctrl_off(slew_ctrl_off), .smbus_levels(smbus_levels), .irq(irq)
);
